// [ism_top.sv]
// Two-wire serial slave front end for a 512 x 8 byte memory
`timescale 1ns/10ps
// Operation
// - 512 bytes addressed by page bit above an 8-bit word address.
// - each array write finishes inside the byte, no ready polling needed.
// - a power-on style reset brings the logic to idle.
// - device is slave only and never drives the serial clock.
// - SDA rising while SCL high is stop; it aborts any operation.
// - SDA falling while SCL high is start; abort and await address.
// - SDA is stable while SCL high; data sampled in high phase.
// - ninth clock is the acknowledge slot, receiver pulls SDA low.
// - SDA high in acknowledge slot is no-acknowledge; abort, readdressable.
// - first byte after start is slave address; top nibble must match.
// - address bits 3 and 2 must match the two select pins.
// - address bit 1 is page, bit 0 direction, one means read.
// - write sends one word-address byte, latched with page bit.
// - read has no word byte; page plus latched low eight bits.
// - address increments after each data byte, wrapping top to zero.
// - no limit on consecutive bytes in one operation.
// - read shifts eight bits, then acknowledge continues or ends read.
// - write takes eight bits then device acknowledges next clock.
// - all bytes travel most significant bit first.
// - drive on falling SCL edge, capture on rising edge.
// - write commits after eighth bit; earlier start or stop saves memory.
// - with protect pin high, data bytes get no ack, no increment.
// - repeated start after word address turns into a read there.
module ism_top
  import ism_pkg::*;
(
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic       scl_clk,
  input  wire logic       sda_i,
  output logic            sda_o,
  output logic            sda_oe,
  input  wire logic [1:0] device_select_pins,
  input  wire logic       write_protect,
  output logic            bus_busy,
  output logic [8:0]      cur_addr
);

  // System clock side
  ism_pins_s       pins_s;
  logic            scl_q_reg;
  logic            sda_q_reg;
  logic            start_seen;
  logic            stop_seen;
  logic            link_hold_reg;
  logic            link_rst_reg;

  // Link clock side
  ism_cfg_s        cfg_s;
  ism_state_e      state_reg;
  logic [3:0]      cnt_reg;
  logic [7:0]      rx_reg;
  logic [7:0]      rx_next;
  logic [7:0]      tx_reg;
  logic [7:0]      rd_data;
  logic            rw_reg;
  logic            bit_reg;
  logic            start_evt;
  logic            stop_evt;
  logic            live;
  logic            byte_end;
  logic            ack_end;
  logic            addr_match;
  logic            read_next;
  logic            wr_en;
  ism_slave_addr_s sa_s;

  // Pins into the system domain
  ism_sync #(
    .WIDTH (2)
  ) u_pin_sync (
    .clk  (sys_clk),
    .rst  (rst),
    .din  ({scl_clk, sda_i}),
    .dout (pins_s)
  );

  // Previous synchronised levels for condition detection
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      scl_q_reg <= 1'b1;
      sda_q_reg <= 1'b1;
    end else begin
      scl_q_reg <= pins_s.scl;
      sda_q_reg <= pins_s.sda;
    end
  end

  // Start and stop seen while the clock stays high
  assign start_seen = scl_q_reg & pins_s.scl & sda_q_reg & ~pins_s.sda;
  assign stop_seen  = scl_q_reg & pins_s.scl & ~sda_q_reg & pins_s.sda;

  // Idle hold: set by reset or stop, freed by start or clock low
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      link_hold_reg <= 1'b1;
    end else if (stop_seen) begin
      link_hold_reg <= 1'b1;
    end else if (start_seen || !pins_s.scl) begin
      link_hold_reg <= 1'b0;
    end
  end

  // Reset of the link domain, taken over from the system domain
  always_ff @(posedge sys_clk) begin
    link_rst_reg <= rst;
  end

  // Bus activity status
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      bus_busy <= 1'b0;
    end else if (stop_seen) begin
      bus_busy <= 1'b0;
    end else if (start_seen) begin
      bus_busy <= 1'b1;
    end
  end

  // Open-drain data always pulls low when enabled
  always_ff @(posedge sys_clk) begin
    sda_o <= 1'b0;
  end

  // Select and protect pins into the link domain
  ism_sync #(
    .WIDTH (3)
  ) u_cfg_sync (
    .clk  (scl_clk),
    .rst  (1'b0),
    .din  ({device_select_pins, write_protect}),
    .dout (cfg_s)
  );

  // Rising edge capture; idle hold arms start detection
  always_ff @(posedge scl_clk or posedge link_hold_reg) begin
    if (link_hold_reg) begin
      bit_reg <= 1'b1;
    end else begin
      bit_reg <= sda_i;
    end
  end

  // SDA moved during the high phase just ended
  assign start_evt = bit_reg & ~sda_i;
  assign stop_evt  = ~bit_reg & sda_i;
  assign live      = ~start_evt & ~stop_evt & (state_reg != ISM_ST_IDLE);
  assign byte_end  = live & (cnt_reg == ISM_LAST_BIT);
  assign ack_end   = live & (cnt_reg == ISM_ACK_SLOT);

  // Received byte, msb first
  assign rx_next = {rx_reg[6:0], bit_reg};
  assign sa_s    = rx_next;

  // Slave address decode
  assign addr_match = (sa_s.dev_type == ISM_DEV_TYPE)
                    & (sa_s.select == cfg_s.select);

  // Another read byte follows this acknowledge slot
  assign read_next = ((state_reg == ISM_ST_ADDR) & rw_reg)
                   | ((state_reg == ISM_ST_RDATA) & ~bit_reg);

  // Array write at the close of an unprotected data byte
  assign wr_en = byte_end & (state_reg == ISM_ST_WDATA) & ~cfg_s.protect;

  ism_mem #(
    .DW    (ISM_DATA_W),
    .AW    (ISM_ADDR_W),
    .DEPTH (ISM_DEPTH)
  ) u_mem (
    .clk     (scl_clk),
    .wr_en   (wr_en),
    .addr    (cur_addr),
    .wr_data (rx_next),
    .rd_data (rd_data)
  );

  // Transfer phase and bit count, advanced on the falling edge
  always_ff @(negedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      state_reg <= ISM_ST_IDLE;
      cnt_reg   <= ISM_CNT_RST;
      rx_reg    <= ISM_BYTE_RST;
      tx_reg    <= ISM_BYTE_RST;
      rw_reg    <= 1'b0;
    end else if (start_evt) begin
      state_reg <= ISM_ST_ADDR;
      cnt_reg   <= ISM_CNT_RST;
    end else if (stop_evt) begin
      state_reg <= ISM_ST_IDLE;
      cnt_reg   <= ISM_CNT_RST;
    end else if (ack_end) begin
      cnt_reg <= ISM_CNT_RST;
      tx_reg  <= rd_data;
      unique case (state_reg)
        ISM_ST_ADDR: begin
          state_reg <= rw_reg ? ISM_ST_RDATA : ISM_ST_WORD;
        end
        ISM_ST_WORD: begin
          state_reg <= ISM_ST_WDATA;
        end
        ISM_ST_WDATA: begin
          state_reg <= ISM_ST_WDATA;
        end
        ISM_ST_RDATA: begin
          if (bit_reg) begin
            state_reg <= ISM_ST_IDLE;
          end
        end
        ISM_ST_IDLE: begin
          state_reg <= ISM_ST_IDLE;
        end
      endcase
    end else if (live) begin
      cnt_reg <= cnt_reg + ISM_CNT_STEP;
      rx_reg  <= rx_next;
      tx_reg  <= {tx_reg[6:0], 1'b0};
      if (byte_end) begin
        unique case (state_reg)
          ISM_ST_ADDR: begin
            rw_reg <= sa_s.read;
            if (!addr_match) begin
              state_reg <= ISM_ST_IDLE;
            end
          end
          ISM_ST_WDATA: begin
            if (cfg_s.protect) begin
              state_reg <= ISM_ST_IDLE;
            end
          end
          ISM_ST_WORD,
          ISM_ST_RDATA,
          ISM_ST_IDLE: begin
            state_reg <= state_reg;
          end
        endcase
      end
    end
  end

  // Address latch: page, word address and increment
  always_ff @(negedge scl_clk or posedge link_rst_reg) begin
    if (link_rst_reg) begin
      cur_addr <= ISM_ADDR_RST;
    end else if (byte_end) begin
      unique case (state_reg)
        ISM_ST_ADDR: begin
          if (addr_match) begin
            cur_addr[8] <= sa_s.page;
          end
        end
        ISM_ST_WORD: begin
          cur_addr[7:0] <= rx_next;
        end
        ISM_ST_WDATA: begin
          if (!cfg_s.protect) begin
            cur_addr <= cur_addr + ISM_ADDR_STEP;
          end
        end
        ISM_ST_RDATA: begin
          cur_addr <= cur_addr + ISM_ADDR_STEP;
        end
        ISM_ST_IDLE: begin
          cur_addr <= cur_addr;
        end
      endcase
    end
  end

  // Data drive on the falling edge; hold releases it at once
  always_ff @(negedge scl_clk or posedge link_hold_reg) begin
    if (link_hold_reg) begin
      sda_oe <= 1'b0;
    end else if (start_evt || stop_evt) begin
      sda_oe <= 1'b0;
    end else if (byte_end) begin
      unique case (state_reg)
        ISM_ST_ADDR: begin
          sda_oe <= addr_match;
        end
        ISM_ST_WORD: begin
          sda_oe <= 1'b1;
        end
        ISM_ST_WDATA: begin
          sda_oe <= ~cfg_s.protect;
        end
        ISM_ST_RDATA,
        ISM_ST_IDLE: begin
          sda_oe <= 1'b0;
        end
      endcase
    end else if (ack_end) begin
      sda_oe <= read_next & ~rd_data[7];
    end else if (live && state_reg == ISM_ST_RDATA) begin
      sda_oe <= ~tx_reg[6];
    end else begin
      sda_oe <= 1'b0;
    end
  end

endmodule

// [ism_pkg.sv]
// Shared constants and types for the two-wire byte memory slave
package ism_pkg;

  // Array shape
  localparam int ISM_ADDR_W = 9;
  localparam int ISM_DATA_W = 8;
  localparam int ISM_DEPTH  = 512;

  // Fixed device-type pattern in slave address bits 7..4
  localparam logic [3:0] ISM_DEV_TYPE = 4'hA;

  // Bit counter marks within one byte plus its acknowledge slot
  localparam logic [3:0] ISM_CNT_RST  = 4'h0;
  localparam logic [3:0] ISM_LAST_BIT = 4'h7;
  localparam logic [3:0] ISM_ACK_SLOT = 4'h8;
  localparam logic [3:0] ISM_CNT_STEP = 4'h1;

  // Reset and step values
  localparam logic [8:0] ISM_ADDR_RST  = 9'h000;
  localparam logic [8:0] ISM_ADDR_STEP = 9'h001;
  localparam logic [7:0] ISM_BYTE_RST  = 8'h00;

  // Transfer phases, one-hot
  typedef enum logic [4:0] {
    ISM_ST_IDLE  = 5'h01,
    ISM_ST_ADDR  = 5'h02,
    ISM_ST_WORD  = 5'h04,
    ISM_ST_WDATA = 5'h08,
    ISM_ST_RDATA = 5'h10
  } ism_state_e;

  // Slave address byte layout, msb first
  typedef struct packed {
    logic [3:0] dev_type;
    logic [1:0] select;
    logic       page;
    logic       read;
  } ism_slave_addr_s;

  // Bus pin pair as seen by the system clock
  typedef struct packed {
    logic scl;
    logic sda;
  } ism_pins_s;

  // Configuration pins as seen by the link clock
  typedef struct packed {
    logic [1:0] select;
    logic       protect;
  } ism_cfg_s;

endpackage

// [ism_sync.sv]
// Two-stage level synchroniser
`timescale 1ns/10ps
module ism_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             clk,
  input  wire logic             rst,
  input  wire logic [WIDTH-1:0] din,
  output logic      [WIDTH-1:0] dout
);

  logic [WIDTH-1:0] meta_reg;

  if (WIDTH < 1) begin : g_bad_width
    $error("ism_sync: WIDTH must be at least 1");
  end

  // First stage feeds only the second stage
  always_ff @(posedge clk) begin
    if (rst) begin
      meta_reg <= '0;
      dout     <= '0;
    end else begin
      meta_reg <= din;
      dout     <= meta_reg;
    end
  end

endmodule

// [ism_mem.sv]
// Byte array with combinational read and write on the falling link edge
`timescale 1ns/10ps
module ism_mem #(
  parameter int DW    = 8,
  parameter int AW    = 9,
  parameter int DEPTH = 512
) (
  input  wire logic          clk,
  input  wire logic          wr_en,
  input  wire logic [AW-1:0] addr,
  input  wire logic [DW-1:0] wr_data,
  output logic      [DW-1:0] rd_data
);

  logic [DW-1:0] mem_reg [DEPTH];

  if (DEPTH < 1 || DEPTH > (1 << AW)) begin : g_bad_depth
    $error("ism_mem: DEPTH must fit the address width");
  end

  // Write completes within the falling edge that ends the byte
  always_ff @(negedge clk) begin
    if (wr_en) begin
      mem_reg[addr] <= wr_data;
    end
  end

  // Read is ready in time for the next drive edge
  assign rd_data = mem_reg[addr];

endmodule

// [ism_top_asserts.sv]
// Concurrent checks on the ports of the two-wire memory slave
`timescale 1ns/10ps
module ism_top_asserts (
  input wire logic       sys_clk,
  input wire logic       rst,
  input wire logic       scl_clk,
  input wire logic       sda_i,
  input wire logic       sda_o,
  input wire logic       sda_oe,
  input wire logic       bus_busy,
  input wire logic [8:0] cur_addr
);
  // All checks sampled on the system clock
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  a_drain_only: assert property (sda_o == 1'b0)
    else $error("sda_o not low");
  a_reset_idle: assert property (disable iff (1'b0)
    rst [*3] |-> !sda_oe && !bus_busy && cur_addr == 9'h000)
    else $error("outputs not idle in reset");
  a_oe_hold: assert property (scl_clk && $past(scl_clk) |-> $stable(sda_oe))
    else $error("sda_oe moved in scl high");
  a_addr_hold: assert property (scl_clk && $past(scl_clk) |-> $stable(cur_addr))
    else $error("cur_addr moved in scl high");
  a_oe_on_low: assert property ($changed(sda_oe) |-> !scl_clk)
    else $error("sda_oe changed with scl high");
  a_start_busy: assert property (scl_clk && $past(scl_clk) && $fell(sda_i)
    |-> ##[1:8] bus_busy)
    else $error("busy missing after start");
  a_stop_idle: assert property (scl_clk && $past(scl_clk) && $rose(sda_i)
    |-> ##[1:8] !bus_busy)
    else $error("busy stuck after stop");
  a_oe_busy: assert property ($rose(sda_oe) |-> bus_busy)
    else $error("drive outside a transfer");
  a_idle_quiet: assert property (!bus_busy && !$past(bus_busy) |-> !sda_oe)
    else $error("drive while idle");

  // Main scenarios
  c_ack: cover property ($rose(sda_oe));
  c_wrap: cover property (cur_addr == 9'h1FF ##[1:100] cur_addr == 9'h000);
  c_end: cover property ($fell(bus_busy));
endmodule

bind ism_top ism_top_asserts i_chk (
  .sys_clk  (sys_clk),
  .rst      (rst),
  .scl_clk  (scl_clk),
  .sda_i    (sda_i),
  .sda_o    (sda_o),
  .sda_oe   (sda_oe),
  .bus_busy (bus_busy),
  .cur_addr (cur_addr)
);

// [ism_master.sv]
// Bus master model making the serial clock and pulling the data line
`timescale 1ns/10ps
module ism_master (
  output logic      scl,
  output logic      sda_low,
  input  wire logic sda
);
  // Clock stands high and data released outside frames
  initial begin
    scl = 1'b1;
    sda_low = 1'b0;
  end

  // One 80 ns clock, data set while clock low
  task automatic bit_io(input logic b, output logic got);
    sda_low = ~b;
    #20 scl = 1'b1;
    #20 got = sda;
    #20 scl = 1'b0;
    #20;
  endtask

  // Start or repeated start, long hold before clock falls
  task automatic start();
    sda_low = 1'b0;
    #20 scl = 1'b1;
    #40 sda_low = 1'b1;
    #160 scl = 1'b0;
    #20;
  endtask

  // Stop, then bus idle
  task automatic stop();
    sda_low = 1'b1;
    #20 scl = 1'b1;
    #40 sda_low = 1'b0;
    #200;
  endtask

  // Byte out msb first, then released acknowledge slot
  task automatic wbyte(input logic [7:0] d, output logic ack);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(d[i], g);
    end
    bit_io(1'b1, g);
    ack = ~g;
  endtask

  // Byte in, then acknowledge only if more wanted
  task automatic rbyte(input logic more, output logic [7:0] d);
    logic g;
    for (int i = 7; i >= 0; i--) begin
      bit_io(1'b1, g);
      d[i] = g;
    end
    bit_io(~more, g);
  endtask
endmodule

// [ism_top_tb.sv]
// Self-checking bench for the two-wire byte memory slave
`timescale 1ns/10ps
module ism_top_tb;
  import ism_pkg::*;
  logic       sys_clk;
  logic       rst;
  logic       scl_clk;
  logic       sda;
  logic       m_low;
  logic       sda_o;
  logic       sda_oe;
  logic [1:0] sel;
  logic       wp;
  logic       bus_busy;
  logic [8:0] cur_addr;
  logic       g;
  int         failures;
  int         n_checks;

  // Open-drain wire with pull-up
  assign sda = (sda_oe ? sda_o : 1'b1) & ~m_low;

  ism_top i_ism_top (
    .sys_clk            (sys_clk),
    .rst                (rst),
    .scl_clk            (scl_clk),
    .sda_i              (sda),
    .sda_o              (sda_o),
    .sda_oe             (sda_oe),
    .device_select_pins (sel),
    .write_protect      (wp),
    .bus_busy           (bus_busy),
    .cur_addr           (cur_addr)
  );

  ism_master i_ism_master (
    .scl     (scl_clk),
    .sda_low (m_low),
    .sda     (sda)
  );

  always #20 sys_clk = ~sys_clk;

  task automatic chk(input string what, input logic [8:0] exp, input logic [8:0] got);
    n_checks++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s exp %h got %h", what, exp, got);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d failures %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Pins change on falling clock, then link phase offset
  task automatic pins(input logic [1:0] s, input logic p);
    @(negedge sys_clk);
    sel = s;
    wp = p;
    #7;
  endtask

  function automatic logic [7:0] sa(input logic [1:0] s, input logic p, input logic r);
    return {ISM_DEV_TYPE, s, p, r};
  endfunction

  task automatic go(input logic [7:0] b, input logic exp);
    logic a;
    i_ism_master.wbyte(b, a);
    chk("ack", {8'h00, exp}, {8'h00, a});
  endtask

  task automatic rd(input logic [7:0] exp, input logic more);
    logic [7:0] d;
    i_ism_master.rbyte(more, d);
    chk("data", {1'b0, exp}, {1'b0, d});
  endtask

  // Hang guard
  initial begin
    #2000000;
    failures++;
    end_of_test();
  end

  initial begin
    sys_clk = 1'b0;
    rst = 1'b1;
    sel = 2'b10;
    wp = 1'b0;
    failures = 0;
    n_checks = 0;
    repeat (16) @(posedge sys_clk);
    #7 chk("addr", ISM_ADDR_RST, cur_addr);
    chk("oe", 9'h000, {8'h00, sda_oe});
    @(negedge sys_clk) rst = 1'b0;
    // Every select code, matching and not
    for (int s = 0; s < 4; s++) begin
      pins(2'(s), 1'b0);
      i_ism_master.start();
      go(sa(2'(s), 1'b0, 1'b0), 1'b1);
      i_ism_master.start();
      go(sa(2'(s) ^ 2'b01, 1'b0, 1'b0), 1'b0);
      i_ism_master.stop();
    end
    pins(2'b10, 1'b0);
    i_ism_master.start();
    go({4'hB, 2'b10, 1'b0, 1'b0}, 1'b0);
    // Sequential write across the top address
    i_ism_master.start();
    go(sa(2'b10, 1'b1, 1'b0), 1'b1);
    chk("busy", 9'h001, {8'h00, bus_busy});
    go(8'hFE, 1'b1);
    go(8'h5A, 1'b1);
    chk("addr", 9'h1FF, cur_addr);
    go(8'hC3, 1'b1);
    chk("addr", 9'h000, cur_addr);
    go(8'h96, 1'b1);
    i_ism_master.stop();
    chk("busy", 9'h000, {8'h00, bus_busy});
    // Random read, then current address read across the wrap
    i_ism_master.start();
    go(sa(2'b10, 1'b1, 1'b0), 1'b1);
    go(8'hFE, 1'b1);
    i_ism_master.start();
    go(sa(2'b10, 1'b1, 1'b1), 1'b1);
    rd(8'h5A, 1'b0);
    i_ism_master.stop();
    i_ism_master.start();
    go(sa(2'b10, 1'b1, 1'b1), 1'b1);
    rd(8'hC3, 1'b1);
    rd(8'h96, 1'b0);
    chk("oe", 9'h000, {8'h00, sda_oe});
    chk("addr", 9'h001, cur_addr);
    i_ism_master.stop();
    // Protected byte refused, no step
    pins(2'b10, 1'b1);
    i_ism_master.start();
    go(sa(2'b10, 1'b0, 1'b0), 1'b1);
    go(8'h00, 1'b1);
    go(8'h11, 1'b0);
    chk("addr", 9'h000, cur_addr);
    i_ism_master.stop();
    // Byte cut short by stop
    pins(2'b10, 1'b0);
    i_ism_master.start();
    go(sa(2'b10, 1'b0, 1'b0), 1'b1);
    go(8'h00, 1'b1);
    for (int i = 0; i < 5; i++) begin
      i_ism_master.bit_io(1'b0, g);
    end
    i_ism_master.stop();
    i_ism_master.start();
    go(sa(2'b10, 1'b0, 1'b0), 1'b1);
    go(8'h00, 1'b1);
    i_ism_master.start();
    go(sa(2'b10, 1'b0, 1'b1), 1'b1);
    rd(8'h96, 1'b0);
    i_ism_master.stop();
    end_of_test();
  end
endmodule
